/* fst_fix.sv */
// fst_fix: rounding, range check and result substitution after subtract
// assumes: the difference core gives a biased true exponent and a guard bit
`include "fst_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fst_fix (
  input wire logic sign,
  input wire logic signed [10:0] exp_in,
  input wire logic [55:0] frac,
  input wire logic is_zero,
  input wire logic dbl,
  input wire logic chop,
  input wire logic ovf_en,
  input wire logic unf_en,
  output logic [63:0] result,
  output logic ovf,
  output logic unf,
  output logic trap
);

  logic [55:0] sum;
  logic [54:0] field;
  logic signed [10:0] exp_r;
  logic signed [10:0] exp_s;

  // round at the precision boundary unless chopping; a clear guard adds
  // nothing, so exact differences pass unchanged
  always_comb begin
    if (dbl) begin
      sum = {1'b0, frac[55:1]} + {55'h0, frac[0] & ~chop};
    end else begin
      sum = {1'b0, frac[55:33], 32'h0} +
            {23'h0, frac[32] & ~chop, 32'h0};
    end
    // carry out of the field renormalises to a clean fraction
    field = sum[55] ? 55'h0 : sum[54:0];
    exp_r = sum[55] ? exp_in + 11'sd1 : exp_in;
  end

  // range check and substitution of the stored word
  always_comb begin
    ovf = !is_zero && (exp_r > `FST_EXP_MAX);
    unf = !is_zero && (exp_r < `FST_EXP_MIN);
    trap = (ovf && ovf_en) || (unf && unf_en);
    exp_s = exp_r;
    if (ovf) begin
      exp_s = exp_r - `FST_EXP_OFS;
    end else if (unf) begin
      exp_s = exp_r + `FST_EXP_OFS;
    end
    if (is_zero || (ovf && !ovf_en) || (unf && !unf_en)) begin
      result = 64'h0; // exact zero
    end else begin
      result = {sign, exp_s[7:0], field};
    end
    if (!dbl) begin
      result[`FST_SGL_LO-1:0] = 32'h0;
    end
  end

endmodule : fst_fix

`default_nettype wire

/* fst_params.svh */
// fst_params.svh: register offsets, field positions and limits of the float unit
// assumes: included by bare name by every file of the block but the assertion module
`ifndef FST_PARAMS_SVH
`define FST_PARAMS_SVH

// register byte offsets on the wishbone bus
`define FST_ADR_FSR 8'h00
`define FST_ADR_CMD 8'h04
`define FST_ADR_ACC_LO 8'h08
`define FST_ADR_ACC_HI 8'h0c
`define FST_ADR_OPN_LO 8'h10
`define FST_ADR_OPN_HI 8'h14

// float status register bit positions
`define FST_FSR_CHOP 0
`define FST_FSR_DBL 1
`define FST_FSR_OVF_EN 2
`define FST_FSR_UNF_EN 3
`define FST_FSR_NZ_EN 4
`define FST_FSR_FC 8
`define FST_FSR_FV 9
`define FST_FSR_FZ 10
`define FST_FSR_FN 11
`define FST_FSR_RESET 32'h0000_0000

// command bits and status fields at the command offset
`define FST_CMD_SUB 0
`define FST_CMD_TST 1
`define FST_STS_BUSY 0
`define FST_STS_CAUSE_LO 1
`define FST_STS_CAUSE_HI 2

// floating word layout: sign, 8-bit excess exponent, 55-bit fraction
`define FST_SIGN 63
`define FST_EXP_HI 62
`define FST_EXP_LO 55
`define FST_SGL_LO 32

// exponent limits and the trap offset (octal 400)
`define FST_EXP_MAX 11'sd255
`define FST_EXP_MIN 11'sd1
`define FST_EXP_OFS 11'sd256

`endif

/* fst_pkg.sv */
// fst_pkg: types and shared decoders of the float subtract and test unit
// assumes: fst_params.svh is on the include path
`include "fst_params.svh"

package fst_pkg;

  // control sequence of the unit
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} fst_state_t;

  // reason of the last floating trap
  typedef enum logic [1:0] {
    CAUSE_NONE, CAUSE_NEGZERO, CAUSE_OVF, CAUSE_UNF
  } fst_cause_t;

  // the undefined value: sign set with a zero exponent
  function automatic logic fst_is_negzero(input logic [63:0] w);
    return w[`FST_SIGN] && (w[`FST_EXP_HI:`FST_EXP_LO] == 8'h00);
  endfunction : fst_is_negzero

  // a zero exponent means zero, whatever the fraction holds
  function automatic logic fst_is_zero(input logic [63:0] w);
    return w[`FST_EXP_HI:`FST_EXP_LO] == 8'h00;
  endfunction : fst_is_zero

endpackage : fst_pkg

/* fst_test.sv */
// fst_test: classification of a test operand into flags and a trap
// assumes: purely combinational, results are registered by the caller
`include "fst_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fst_test (
  input wire logic [63:0] opnd,
  input wire logic negzero_trap_enable,
  output logic trap,
  output logic zero,
  output logic negative
);

  // only the sign and exponent are looked at, so precision cannot matter
  always_comb begin
    trap = negzero_trap_enable && fst_pkg::fst_is_negzero(opnd);
    zero = fst_pkg::fst_is_zero(opnd);
    negative = opnd[`FST_SIGN] && !fst_pkg::fst_is_zero(opnd);
  end

endmodule : fst_test

`default_nettype wire

/* fst_unit.sv */
// fst_unit: float subtract exception handling and float test, wishbone slave
// assumes: an external difference core answers SUB_REQ with DIFF_VALID;
// all inputs synchronous to MCLK; the DIFF_* inputs need be valid only with DIFF_VALID
// limitation: CE low also stalls the bus answer, so a master must not time out on it
// limitation: a start while busy is acked but dropped; software polls the busy bit
// limitation: a status write leaves the flags alone; only the next op updates them
//
// Overview of operation
// - subtract overflow or underflow with trap disabled stores exact zero
// - subtract uses single or double precision, rounds or chops, per status bits
// - negative-zero source with trap enabled traps before subtract, accumulator kept
// - enabled overflow or underflow traps, faulty result stored, fraction correct
// - trapped overflow stores exponent reduced by octal 400
// - trapped underflow stores exponent raised by octal 400; zero stored correctly
// - negative zero result appears only with overflow or underflow
// - negative zero result written only when its trap is enabled
// - like-signed operands, exponents differing by 0 or 1, give exact results
// - test clears carry and overflow, sets zero and negative from operand
// - test traps before execution on negative zero when trap enabled
// - test never signals overflow or underflow
// - test is exact in both precisions
//
// Added by the designer: the address map and the Wishbone slave port.
`include "fst_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fst_unit #(
  parameter int ADR_W = 8
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic SUB_REQ,
  output logic [63:0] SUB_MINUEND,
  output logic [63:0] SUB_SUBTRAHEND,
  output logic SUB_DOUBLE,
  output logic SUB_CHOP,
  input wire logic DIFF_VALID,
  input wire logic DIFF_SIGN,
  input wire logic signed [10:0] DIFF_EXP,
  input wire logic [55:0] DIFF_FRAC,
  input wire logic DIFF_ZERO,
  output logic FLOAT_TRAP
);

  // the decode compares against 8-bit offsets
  if (ADR_W < 8) begin : g_chk
    $error("fst_unit: ADR_W must be at least 8");
  end

  // merge a written word into a register under byte enables
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // software controls of the float status register
  logic chop_select;
  logic double_precision_select;
  logic overflow_trap_enable;
  logic underflow_trap_enable;
  logic negzero_trap_enable;
  // condition flags
  logic float_carry_flag;
  logic float_overflow_flag;
  logic float_zero_flag;
  logic float_negative_flag;
  // accumulator and source operand
  logic [63:0] float_target_register;
  logic [63:0] float_source_operand;

  fst_pkg::fst_state_t state;
  fst_pkg::fst_cause_t cause;

  logic acc_req;
  logic wr;
  logic [7:0] adr;
  logic [31:0] fsr_word;
  logic [31:0] sts_word;
  logic [31:0] rd_word;
  logic float_subtract_op;
  logic float_test_op;

  logic tst_trap;
  logic tst_zero;
  logic tst_neg;
  logic sub_nz_trap;

  logic [63:0] fix_result;
  logic fix_ovf;
  logic fix_unf;
  logic fix_trap;
  logic busy;
  logic sub_done;

  // status reset value; control bits and flags are both taken from it
  localparam logic [31:0] FSR_RST = `FST_FSR_RESET;

  // a new access is one not already being answered
  assign acc_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr = acc_req && WB_WE_I;
  assign adr = WB_ADR_I[7:0];

  // one decode of the busy state, shared by the request, status and result paths
  assign busy = (state == fst_pkg::ST_WAIT);
  // the core answer counts only while a subtract is outstanding
  assign sub_done = busy && DIFF_VALID;

  // commands start only from idle; a start while busy is dropped
  assign float_subtract_op = wr && (adr == `FST_ADR_CMD) && WB_SEL_I[0] &&
                             WB_DAT_I[`FST_CMD_SUB] && (state == fst_pkg::ST_IDLE);
  assign float_test_op = wr && (adr == `FST_ADR_CMD) && WB_SEL_I[0] &&
                         WB_DAT_I[`FST_CMD_TST] && !WB_DAT_I[`FST_CMD_SUB] &&
                         (state == fst_pkg::ST_IDLE);

  // the source is checked before the core is ever asked
  assign sub_nz_trap = negzero_trap_enable &&
                       fst_pkg::fst_is_negzero(float_source_operand);

  // test operand classification, operand is the source register
  fst_test i_fst_test (
    .opnd(float_source_operand),
    .negzero_trap_enable(negzero_trap_enable),
    .trap(tst_trap),
    .zero(tst_zero),
    .negative(tst_neg)
  );

  // result fix-up of the difference handed back by the core
  fst_fix i_fst_fix (
    .sign(DIFF_SIGN),
    .exp_in(DIFF_EXP),
    .frac(DIFF_FRAC),
    .is_zero(DIFF_ZERO),
    .dbl(double_precision_select),
    .chop(chop_select),
    .ovf_en(overflow_trap_enable),
    .unf_en(underflow_trap_enable),
    .result(fix_result),
    .ovf(fix_ovf),
    .unf(fix_unf),
    .trap(fix_trap)
  );

  // operands and mode to the difference core; precision comes from status
  // and feeds the fix-up as well, so both halves round the same way
  assign SUB_MINUEND = float_target_register;
  assign SUB_SUBTRAHEND = float_source_operand;
  assign SUB_DOUBLE = double_precision_select;
  assign SUB_CHOP = chop_select;
  assign SUB_REQ = busy;

  // wishbone answers one cycle after the strobe, every offset acked
  // acc_req excludes the ack cycle, so a strobe still held is not answered twice
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
    end else if (CE) begin
      WB_ACK_O <= acc_req;
    end
  end

  // packed views of the status and command words
  always_comb begin
    fsr_word = 32'h0;
    fsr_word[`FST_FSR_CHOP] = chop_select;
    fsr_word[`FST_FSR_DBL] = double_precision_select;
    fsr_word[`FST_FSR_OVF_EN] = overflow_trap_enable;
    fsr_word[`FST_FSR_UNF_EN] = underflow_trap_enable;
    fsr_word[`FST_FSR_NZ_EN] = negzero_trap_enable;
    fsr_word[`FST_FSR_FC] = float_carry_flag;
    fsr_word[`FST_FSR_FV] = float_overflow_flag;
    fsr_word[`FST_FSR_FZ] = float_zero_flag;
    fsr_word[`FST_FSR_FN] = float_negative_flag;
    sts_word = 32'h0;
    sts_word[`FST_STS_BUSY] = busy;
    sts_word[`FST_STS_CAUSE_HI:`FST_STS_CAUSE_LO] = cause;
  end

  // read multiplexer, unmapped offsets read zero
  always_comb begin
    unique case (adr)
      `FST_ADR_FSR: rd_word = fsr_word;
      `FST_ADR_CMD: rd_word = sts_word;
      `FST_ADR_ACC_LO: rd_word = float_target_register[31:0];
      `FST_ADR_ACC_HI: rd_word = float_target_register[63:32];
      `FST_ADR_OPN_LO: rd_word = float_source_operand[31:0];
      `FST_ADR_OPN_HI: rd_word = float_source_operand[63:32];
      default: rd_word = 32'h0;
    endcase
  end

  // read data is captured with the ack so it comes from flops
  // writes return zero so a stale word never looks like read data
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      WB_DAT_O <= 32'h0;
    end else if (CE && acc_req) begin
      WB_DAT_O <= WB_WE_I ? 32'h0 : rd_word;
    end
  end

  // status control bits; flags in the same word are read only
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      chop_select <= FSR_RST[`FST_FSR_CHOP];
      double_precision_select <= FSR_RST[`FST_FSR_DBL];
      overflow_trap_enable <= FSR_RST[`FST_FSR_OVF_EN];
      underflow_trap_enable <= FSR_RST[`FST_FSR_UNF_EN];
      negzero_trap_enable <= FSR_RST[`FST_FSR_NZ_EN];
    end else if (CE && wr && (adr == `FST_ADR_FSR) && WB_SEL_I[0]) begin
      chop_select <= WB_DAT_I[`FST_FSR_CHOP];
      double_precision_select <= WB_DAT_I[`FST_FSR_DBL];
      overflow_trap_enable <= WB_DAT_I[`FST_FSR_OVF_EN];
      underflow_trap_enable <= WB_DAT_I[`FST_FSR_UNF_EN];
      negzero_trap_enable <= WB_DAT_I[`FST_FSR_NZ_EN];
    end
  end

  // source operand: software only; test never writes it back
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      float_source_operand <= 64'h0;
    end else if (CE && wr && (adr == `FST_ADR_OPN_LO)) begin
      float_source_operand[31:0] <= merge(float_source_operand[31:0],
                                          WB_DAT_I, WB_SEL_I);
    end else if (CE && wr && (adr == `FST_ADR_OPN_HI)) begin
      float_source_operand[63:32] <= merge(float_source_operand[63:32],
                                           WB_DAT_I, WB_SEL_I);
    end
  end

  // accumulator: the subtract result wins; software writes are taken
  // only while idle so a result cannot be half overwritten
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      float_target_register <= 64'h0;
    end else if (CE) begin
      if (sub_done) begin
        // trapped range errors keep the faulty word, untrapped ones an exact zero
        float_target_register <= fix_result;
      end else if (state == fst_pkg::ST_IDLE && wr &&
                   adr == `FST_ADR_ACC_LO) begin
        float_target_register[31:0] <= merge(float_target_register[31:0],
                                             WB_DAT_I, WB_SEL_I);
      end else if (state == fst_pkg::ST_IDLE && wr &&
                   adr == `FST_ADR_ACC_HI) begin
        float_target_register[63:32] <= merge(float_target_register[63:32],
                                              WB_DAT_I, WB_SEL_I);
      end
    end
  end

  // sequencer: a subtract waits on the core unless it traps up front
  // a negative-zero source with its trap enabled never leaves idle, so the core is never asked
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state <= fst_pkg::ST_IDLE;
    end else if (CE) begin
      unique case (state)
        fst_pkg::ST_IDLE: begin
          if (float_subtract_op && !sub_nz_trap) begin
            state <= fst_pkg::ST_WAIT;
          end
        end
        fst_pkg::ST_WAIT: begin
          if (DIFF_VALID) begin
            state <= fst_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // condition flags; a trap before execution leaves them as they were
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      float_carry_flag <= FSR_RST[`FST_FSR_FC];
      float_overflow_flag <= FSR_RST[`FST_FSR_FV];
      float_zero_flag <= FSR_RST[`FST_FSR_FZ];
      float_negative_flag <= FSR_RST[`FST_FSR_FN];
    end else if (CE) begin
      if (float_test_op && !tst_trap) begin
        float_carry_flag <= 1'b0;
        float_overflow_flag <= 1'b0;
        float_zero_flag <= tst_zero;
        float_negative_flag <= tst_neg;
      end else if (sub_done) begin
        // zero and negative follow the stored word, so a trapped negative zero reads as zero
        float_carry_flag <= 1'b0;
        float_overflow_flag <= fix_ovf;
        float_zero_flag <= fst_pkg::fst_is_zero(fix_result);
        float_negative_flag <= fix_result[`FST_SIGN] &&
                               !fst_pkg::fst_is_zero(fix_result);
      end
    end
  end

  // trap request is a one-cycle pulse; cause holds until the next op
  // commands need idle and answers need busy, so the branches never meet
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      FLOAT_TRAP <= 1'b0;
      cause <= fst_pkg::CAUSE_NONE;
    end else if (CE) begin
      FLOAT_TRAP <= 1'b0;
      if (float_subtract_op && sub_nz_trap) begin
        FLOAT_TRAP <= 1'b1;
        cause <= fst_pkg::CAUSE_NEGZERO;
      end else if (float_test_op) begin
        // test can raise nothing but the negative-zero trap
        FLOAT_TRAP <= tst_trap;
        cause <= tst_trap ? fst_pkg::CAUSE_NEGZERO : fst_pkg::CAUSE_NONE;
      end else if (float_subtract_op) begin
        cause <= fst_pkg::CAUSE_NONE;
      end else if (sub_done && fix_trap) begin
        FLOAT_TRAP <= 1'b1;
        cause <= fix_unf ? fst_pkg::CAUSE_UNF : fst_pkg::CAUSE_OVF;
      end
    end
  end

endmodule : fst_unit

`default_nettype wire

/* fst_unit_asserts.sv */
// fst_unit_asserts: port-level checks of the float subtract and test unit
// assumes: bound to fst_unit, one clock domain, CE held high while checked
`timescale 1ns/1ps
`default_nettype none

module fst_unit_asserts #(
  parameter int ADR_W = 8
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic SUB_REQ,
  input wire logic [63:0] SUB_MINUEND,
  input wire logic [63:0] SUB_SUBTRAHEND,
  input wire logic SUB_DOUBLE,
  input wire logic SUB_CHOP,
  input wire logic DIFF_VALID,
  input wire logic DIFF_SIGN,
  input wire logic signed [10:0] DIFF_EXP,
  input wire logic [55:0] DIFF_FRAC,
  input wire logic DIFF_ZERO,
  input wire logic FLOAT_TRAP
);
  logic take, wr_cmd, cmd_sub, cmd_tst, nz_src, fin;
  logic nz_en, unf_en, ovf_en, dbl, chop;
  // decode of taken bus requests, the source operand and the core answer
  assign take = CE && WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_cmd = take && WB_WE_I && WB_ADR_I[7:0] == 8'h04 && WB_SEL_I[0];
  assign cmd_sub = wr_cmd && WB_DAT_I[0];
  assign cmd_tst = wr_cmd && !WB_DAT_I[0] && WB_DAT_I[1];
  assign nz_src = SUB_SUBTRAHEND[63] && SUB_SUBTRAHEND[62:55] == 8'h00;
  assign fin = CE && SUB_REQ && DIFF_VALID;
  // shadow of the control bits; only byte lane 0 reaches them
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      {nz_en, unf_en, ovf_en, dbl, chop} <= 5'h00;
    end else if (take && WB_WE_I && WB_ADR_I[7:0] == 8'h00 && WB_SEL_I[0]) begin
      {nz_en, unf_en, ovf_en, dbl, chop} <= WB_DAT_I[4:0];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  AST_ACK_PULSE: assert property (take |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus ack is not a single cycle after the request");
  AST_SUB_START: assert property (
    cmd_sub && !SUB_REQ && !(nz_en && nz_src) |=> SUB_REQ && !FLOAT_TRAP)
    else $error("subtract did not start");
  AST_NZ_SUB: assert property (
    cmd_sub && !SUB_REQ && nz_en && nz_src |-> ##[1:2] (FLOAT_TRAP && !SUB_REQ))
    else $error("negative zero source did not trap");
  AST_REQ_HOLD: assert property (SUB_REQ && !DIFF_VALID |=> SUB_REQ && $stable(SUB_MINUEND))
    else $error("request dropped or accumulator moved while busy");
  AST_REQ_END: assert property (fin |=> !SUB_REQ)
    else $error("request stayed up after the answer");
  AST_UNTRAP: assert property (
    fin && !DIFF_ZERO && ((DIFF_EXP > 11'sd255 && !ovf_en) || (DIFF_EXP < 11'sd0 && !unf_en))
    |=> SUB_MINUEND == 64'h0 && !FLOAT_TRAP)
    else $error("untrapped range error did not store zero");
  AST_TRAP_STORE: assert property (
    fin && chop && dbl && !DIFF_ZERO
    && ((DIFF_EXP > 11'sd255 && ovf_en) || (DIFF_EXP < 11'sd0 && unf_en))
    |=> FLOAT_TRAP && SUB_MINUEND[63] == $past(DIFF_SIGN)
    && SUB_MINUEND[62:55] == 8'($past(DIFF_EXP)) && SUB_MINUEND[54:0] == 55'($past(DIFF_FRAC) >> 1))
    else $error("trapped range error stored a wrong word");
  AST_NEGZ: assert property (
    fin ##1 (SUB_MINUEND[63] && SUB_MINUEND[62:55] == 8'h00) |-> FLOAT_TRAP)
    else $error("negative zero stored without a trap");
  AST_TST_TRAP: assert property (cmd_tst && nz_en && nz_src |-> ##[1:2] FLOAT_TRAP)
    else $error("test of negative zero did not trap");
  AST_TST_KEEP: assert property (
    cmd_tst && !SUB_REQ |=> $stable(SUB_MINUEND) && $stable(SUB_SUBTRAHEND) && !SUB_REQ)
    else $error("test changed an operand or started the core");
  AST_PREC: assert property (SUB_REQ |-> SUB_DOUBLE == dbl && SUB_CHOP == chop)
    else $error("precision or chop select differs from status");
endmodule : fst_unit_asserts

bind fst_unit fst_unit_asserts #(.ADR_W(ADR_W)) i_fst_unit_asserts (
  .MCLK(MCLK), .NRST(NRST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SUB_REQ(SUB_REQ), .SUB_MINUEND(SUB_MINUEND),
  .SUB_SUBTRAHEND(SUB_SUBTRAHEND), .SUB_DOUBLE(SUB_DOUBLE), .SUB_CHOP(SUB_CHOP),
  .DIFF_VALID(DIFF_VALID), .DIFF_SIGN(DIFF_SIGN), .DIFF_EXP(DIFF_EXP),
  .DIFF_FRAC(DIFF_FRAC), .DIFF_ZERO(DIFF_ZERO), .FLOAT_TRAP(FLOAT_TRAP));
`default_nettype wire

/* tb_fst_unit.sv */
// tb_fst_unit: directed bench for the float subtract and test unit
// assumes: the bench is both bus master and difference core; CE stays high
`include "fst_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_fst_unit;
  localparam logic [63:0] A0 = 64'h4080_0000_0000_0000;
  localparam logic [63:0] B0 = 64'h4080_0000_0000_0001;
  localparam logic [63:0] NZ = 64'h8000_0000_0000_0005;
  localparam logic [55:0] FR = 56'hc3_2100_0000_00ff;
  localparam logic [54:0] FH = FR[55:1];
  logic MCLK = 1'b0, NRST = 1'b0, CE = 1'b1;
  logic WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
  logic WB_ACK_O, SUB_REQ, SUB_DOUBLE, SUB_CHOP, FLOAT_TRAP;
  logic [63:0] SUB_MINUEND, SUB_SUBTRAHEND;
  logic DIFF_VALID = 1'b0, DIFF_SIGN = 1'b0, DIFF_ZERO = 1'b0;
  logic signed [10:0] DIFF_EXP = 11'sd0;
  logic [55:0] DIFF_FRAC = 56'h0;
  int bad_count = 0, tests_run = 0, traps = 0, cycles = 0;

  fst_unit i_fst_unit (
    .MCLK(MCLK), .NRST(NRST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SUB_REQ(SUB_REQ), .SUB_MINUEND(SUB_MINUEND),
    .SUB_SUBTRAHEND(SUB_SUBTRAHEND), .SUB_DOUBLE(SUB_DOUBLE), .SUB_CHOP(SUB_CHOP),
    .DIFF_VALID(DIFF_VALID), .DIFF_SIGN(DIFF_SIGN), .DIFF_EXP(DIFF_EXP),
    .DIFF_FRAC(DIFF_FRAC), .DIFF_ZERO(DIFF_ZERO), .FLOAT_TRAP(FLOAT_TRAP));

  always #5 MCLK = ~MCLK;

  // watchdog and tally of trap pulses; a run is a few hundred cycles
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (FLOAT_TRAP === 1'b1) traps <= traps + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end

  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    tests_run++;
    if (got !== want) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk

  // one classic cycle; held until ack is seen, read data kept in rd
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_SEL_I <= 4'hf;
    WB_DAT_I <= d;
    do @(posedge MCLK); while (WB_ACK_O !== 1'b1);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [7:0] a, input logic [31:0] want);
    wb(1'b0, a, 32'h0);
    chk({32'h0, rd}, {32'h0, want});
  endtask : rchk

  task automatic w64(input logic [7:0] a, input logic [63:0] v);
    wb(1'b1, a, v[31:0]);
    wb(1'b1, a + 8'h04, v[63:32]);
  endtask : w64

  // load status, accumulator and source, issue a command, play the core,
  // then check accumulator, flags and the number of trap pulses
  task automatic op(input logic [4:0] ctl, input logic [63:0] b, input logic [1:0] code,
      input logic [1:0] sz, input logic signed [10:0] e, input logic [55:0] f,
      input logic [63:0] want, input logic [3:0] fl, input int tr);
    int t0;
    logic [31:0] lo;
    logic run;
    run = code == 2'd1 && !(ctl[4] && b[63] && b[62:55] == 8'h00);
    wb(1'b1, `FST_ADR_FSR, {27'h0, ctl});
    w64(`FST_ADR_ACC_LO, A0);
    w64(`FST_ADR_OPN_LO, b);
    t0 = traps;
    wb(1'b1, `FST_ADR_CMD, {30'h0, code});
    if (run) begin
      do @(posedge MCLK); while (SUB_REQ !== 1'b1);
      chk(SUB_MINUEND, A0);
      chk(SUB_SUBTRAHEND, b);
      chk({62'h0, SUB_DOUBLE, SUB_CHOP}, {62'h0, ctl[1:0]});
      DIFF_VALID <= 1'b1;
      {DIFF_SIGN, DIFF_ZERO} <= sz;
      DIFF_EXP <= e;
      DIFF_FRAC <= f;
      @(posedge MCLK);
      DIFF_VALID <= 1'b0;
      DIFF_EXP <= ~e;
      DIFF_FRAC <= ~f;
    end else begin
      repeat (3) @(posedge MCLK);
      chk({63'h0, SUB_REQ}, 64'h0);
    end
    wb(1'b0, `FST_ADR_ACC_LO, 32'h0);
    lo = rd;
    wb(1'b0, `FST_ADR_ACC_HI, 32'h0);
    chk({rd, lo}, want);
    wb(1'b0, `FST_ADR_FSR, 32'h0);
    chk({32'h0, rd}, {32'h0, 20'h0, fl, 3'h0, ctl});
    chk(64'(traps - t0), 64'(tr));
  endtask : op

  // main sequence: reset, register map, subtract cases, then test cases
  initial begin
    repeat (16) @(posedge MCLK);
    NRST <= 1'b1;
    rchk(`FST_ADR_FSR, `FST_FSR_RESET);
    rchk(`FST_ADR_CMD, 32'h0);
    wb(1'b1, 8'h1c, 32'hffff_ffff);
    rchk(8'h1c, 32'h0);
    wb(1'b1, `FST_ADR_FSR, 32'h0000_0f1f);
    rchk(`FST_ADR_FSR, 32'h0000_001f);
    op(5'h03, B0, 2'd1, 2'b00, 11'sd100, FR, {1'b0, 8'h64, FH}, 4'h0, 0);
    op(5'h02, B0, 2'd1, 2'b00, 11'sd100, FR, {1'b0, 8'h64, FH + 55'h1}, 4'h0, 0);
    op(5'h00, B0, 2'd1, 2'b10, 11'sd100, 56'h80_0001_0000_0000,
       64'hb240_0001_0000_0000, 4'h8, 0);
    op(5'h03, B0, 2'd1, 2'b10, 11'sd300, FR, 64'h0, 4'h6, 0);
    op(5'h07, B0, 2'd1, 2'b00, 11'sd300, FR, {1'b0, 8'h2c, FH}, 4'h2, 1);
    rchk(`FST_ADR_CMD, 32'h4);
    op(5'h03, B0, 2'd1, 2'b00, -11'sd10, FR, 64'h0, 4'h4, 0);
    op(5'h0b, B0, 2'd1, 2'b10, -11'sd10, FR, {1'b1, 8'hf6, FH}, 4'h8, 1);
    rchk(`FST_ADR_CMD, 32'h6);
    op(5'h0b, B0, 2'd1, 2'b01, -11'sd10, FR, 64'h0, 4'h4, 0);
    op(5'h07, B0, 2'd1, 2'b10, 11'sd256, FR, {1'b1, 8'h00, FH}, 4'h6, 1);
    op(5'h13, NZ, 2'd1, 2'b00, 11'sd0, FR, A0, 4'h6, 1);
    rchk(`FST_ADR_CMD, 32'h2);
    op(5'h03, B0, 2'd2, 2'b00, 11'sd0, FR, A0, 4'h0, 0);
    op(5'h00, 64'hc080_0000_0000_0000, 2'd2, 2'b00, 11'sd0, FR, A0, 4'h8, 0);
    op(5'h03, 64'h0, 2'd2, 2'b00, 11'sd0, FR, A0, 4'h4, 0);
    op(5'h03, NZ, 2'd2, 2'b00, 11'sd0, FR, A0, 4'h4, 0);
    op(5'h13, NZ, 2'd2, 2'b00, 11'sd0, FR, A0, 4'h4, 1);
    rchk(`FST_ADR_CMD, 32'h2);
    final_report();
  end
endmodule : tb_fst_unit
`default_nettype wire
